// file: rtl/nsx_consts.svh
`ifndef NSX_CONSTS_SVH
`define NSX_CONSTS_SVH

// ----------------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------------
`define NSX_WORD_W         12
`define NSX_DATA_W         8
`define NSX_FADDR_W        5
`define NSX_DEST_BIT       5
`define NSX_NIBBLE_W       4

// ----------------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------------
`define NSX_SWAP_PAT       6'h0e
`define NSX_XORF_PAT       6'h06
`define NSX_XORL_PAT       4'hf
`define NSX_DIRL_PAT       9'h000
`define NSX_DIRL_PORT      3'h6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define NSX_ACC_RST        8'h00
`define NSX_DIR_RST        8'hff
`define NSX_ZERO_RST       1'h0

`endif

// file: rtl/nsx_pkg.sv
package nsx_pkg;

    // ------------------------------------------------------------------
    // operation kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        NSX_OP_NONE,
        NSX_OP_SWAP,
        NSX_OP_DIRL,
        NSX_OP_XORL,
        NSX_OP_XORF,
        NSX_OP_OTHER
    } nsx_op_t;

    // ------------------------------------------------------------------
    // request from the fetch stage: word plus the addressed file value
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [11:0] word;
        logic [7:0]  file_data;
    } nsx_req_t;

    // ------------------------------------------------------------------
    // decoded fields
    // ------------------------------------------------------------------
    typedef struct packed {
        nsx_op_t     op;
        logic        to_file;
        logic [4:0]  faddr;
        logic [7:0]  literal;
    } nsx_dec_t;

    // ------------------------------------------------------------------
    // write-back to the file register array
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        we;
        logic [4:0]  addr;
        logic [7:0]  data;
    } nsx_fwr_t;

endpackage : nsx_pkg

// file: rtl/nsx_decode.sv
`timescale 1ns/10ps
`include "nsx_consts.svh"

module nsx_decode
    import nsx_pkg::*;
(
    input  wire logic [11:0] word_in,
    input  wire logic        valid_in,
    output nsx_dec_t         dec_out
);

    // ------------------------------------------------------------------
    // opcode match
    // ------------------------------------------------------------------
    wire is_swap = (word_in[11:6] == `NSX_SWAP_PAT);
    wire is_xorf = (word_in[11:6] == `NSX_XORF_PAT);
    wire is_xorl = (word_in[11:8] == `NSX_XORL_PAT);
    // only operand 6 names a port; other operands of this pattern
    // belong to unrelated instructions and are left to the core
    wire is_dirl = (word_in[11:3] == `NSX_DIRL_PAT)
                 && (word_in[2:0] == `NSX_DIRL_PORT);

    wire nsx_op_t op_sel = !valid_in ? NSX_OP_NONE :
                           is_swap   ? NSX_OP_SWAP :
                           is_xorf   ? NSX_OP_XORF :
                           is_xorl   ? NSX_OP_XORL :
                           is_dirl   ? NSX_OP_DIRL : NSX_OP_OTHER;

    assign dec_out.op      = op_sel;
    assign dec_out.to_file = word_in[`NSX_DEST_BIT];
    assign dec_out.faddr   = word_in[`NSX_FADDR_W-1:0];
    assign dec_out.literal = word_in[`NSX_DATA_W-1:0];

endmodule : nsx_decode

// file: rtl/nsx_exec.sv
`timescale 1ns/10ps
`include "nsx_consts.svh"

// Function
// - nibble swap exchanges high and low nibbles of a file register, flags untouched
// - nibble swap destination bit 0 writes accumulator, 1 writes file register
// - direction load with operand 6 copies accumulator to port direction register
// - literal xor replaces accumulator with accumulator xor literal, only zero flag
// - file xor computes accumulator xor file register, updates only zero flag
// - file xor destination bit 0 writes accumulator, 1 writes file register
module nsx_exec
    import nsx_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire nsx_req_t    req_in,
    input  wire logic        acc_load_in,
    input  wire logic [7:0]  acc_load_data_in,
    output logic [7:0]       acc_out,
    output logic [7:0]       dir_out,
    output logic             zero_out,
    output nsx_fwr_t         fwr_out,
    output logic             done_out,
    output logic             other_out,
    output nsx_op_t          last_op_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  acc_ff;
    logic [7:0]  dir_ff;
    logic        zero_ff;
    nsx_fwr_t    fwr_ff;
    logic        done_ff;
    logic        other_ff;
    nsx_op_t     last_op_ff;

    logic [7:0]  nxt_acc;
    logic [7:0]  nxt_dir;
    logic        nxt_zero;
    nsx_fwr_t    nxt_fwr;
    logic        nxt_done;
    logic        nxt_other;
    nsx_op_t     nxt_last_op;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    nsx_dec_t    dec;

    nsx_decode u_decode (
        .word_in  (req_in.word),
        .valid_in (req_in.valid),
        .dec_out  (dec)
    );

    // one-hot view of the decoded kind
    wire op_swap  = (dec.op == NSX_OP_SWAP);
    wire op_dirl  = (dec.op == NSX_OP_DIRL);
    wire op_xorl  = (dec.op == NSX_OP_XORL);
    wire op_xorf  = (dec.op == NSX_OP_XORF);
    wire op_other = (dec.op == NSX_OP_OTHER);
    wire op_ours  = op_swap | op_dirl | op_xorl | op_xorf;

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    // the file operand arrives with the word, so the swap needs no read
    // cycle of its own and finishes in the same cycle it is taken
    // nothing is forwarded here: a write-back lands in the file array one
    // cycle later, so the caller bypasses it into file_data when the next
    // word names the same register
    wire [7:0] swap_res = {req_in.file_data[3:0],
                           req_in.file_data[7:4]};
    wire [7:0] xorl_res = acc_ff ^ dec.literal;
    wire [7:0] xorf_res = acc_ff ^ req_in.file_data;

    wire [7:0] alu_res  = op_swap ? swap_res :
                          op_xorl ? xorl_res :
                          op_xorf ? xorf_res : acc_ff;

    // the literal form has no destination bit: bit 5 is literal data
    wire swap_to_acc  = op_swap && !dec.to_file;
    wire swap_to_file = op_swap && dec.to_file;
    wire xorf_to_acc  = op_xorf && !dec.to_file;
    wire xorf_to_file = op_xorf && dec.to_file;
    wire to_file      = swap_to_file | xorf_to_file;
    wire to_acc       = swap_to_acc | xorf_to_acc | op_xorl;
    wire sets_zero    = op_xorl | op_xorf;
    wire res_zero     = (alu_res == 8'h00);
    wire side_load    = acc_load_in && !to_acc;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // an instruction that writes the accumulator wins over the side load;
    // the side load stands in for the rest of the instruction set
    always_comb begin
        nxt_acc = acc_ff;
        if (to_acc) begin
            nxt_acc = alu_res;
        end else if (side_load) begin
            nxt_acc = acc_load_data_in;
        end
    end

    always_comb begin
        nxt_dir = dir_ff;
        if (op_dirl) begin
            nxt_dir = acc_ff;
        end
    end

    // swap and direction load leave the flag alone
    always_comb begin
        nxt_zero = zero_ff;
        if (sets_zero) begin
            nxt_zero = res_zero;
        end
    end

    always_comb begin
        nxt_fwr.we   = to_file;
        nxt_fwr.addr = dec.faddr;
        nxt_fwr.data = alu_res;
    end

    always_comb begin
        nxt_done  = op_ours;
        nxt_other = op_other;
    end

    always_comb begin
        nxt_last_op = last_op_ff;
        case (dec.op)
            NSX_OP_SWAP,
            NSX_OP_DIRL,
            NSX_OP_XORL,
            NSX_OP_XORF: begin
                nxt_last_op = dec.op;
            end
            NSX_OP_NONE,
            NSX_OP_OTHER: begin
                nxt_last_op = last_op_ff;
            end
            default: begin
                nxt_last_op = last_op_ff;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            acc_ff <= `NSX_ACC_RST;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    // all ones after reset so every port pin starts as an input
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            dir_ff <= `NSX_DIR_RST;
        end else begin
            dir_ff <= nxt_dir;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            zero_ff <= `NSX_ZERO_RST;
        end else begin
            zero_ff <= nxt_zero;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            fwr_ff <= '0;
        end else begin
            fwr_ff <= nxt_fwr;
        end
    end

    // done and other are one-cycle pulses: they drop at the next edge
    // unless another word that sets the same pulse is taken there
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            done_ff  <= 1'b0;
            other_ff <= 1'b0;
        end else begin
            done_ff  <= nxt_done;
            other_ff <= nxt_other;
        end
    end

    // the last handled kind survives words that are not ours
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            last_op_ff <= NSX_OP_NONE;
        end else begin
            last_op_ff <= nxt_last_op;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // every output is a register; nothing combinational reaches a pin
    assign acc_out     = acc_ff;
    assign dir_out     = dir_ff;
    assign zero_out    = zero_ff;
    assign fwr_out     = fwr_ff;
    assign done_out    = done_ff;
    assign other_out   = other_ff;
    assign last_op_out = last_op_ff;

endmodule : nsx_exec

// file: testbench/nsx_exec_chk.sv
`timescale 1ns/10ps
module nsx_exec_chk
    import nsx_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       srst_in,
    input wire nsx_req_t   req_in,
    input wire logic       acc_load_in,
    input wire logic [7:0] acc_out,
    input wire logic [7:0] dir_out,
    input wire logic       zero_out,
    input wire nsx_fwr_t   fwr_out,
    input wire logic       done_out
);
    wire [11:0] w   = req_in.word;
    wire [7:0]  fd  = req_in.file_data;
    wire [4:0]  fa  = w[4:0];
    wire        sw  = req_in.valid && w[11:6] == 6'h0e;
    wire        xf  = req_in.valid && w[11:6] == 6'h06;
    wire        xl  = req_in.valid && w[11:8] == 4'hf;
    wire        dl  = req_in.valid && w == 12'h006;
    wire [7:0]  swp = {fd[3:0], fd[7:4]};
    wire [7:0]  xr  = acc_out ^ (xl ? w[7:0] : fd);

    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);

    a_swap_acc: assert property (
        sw && !w[5] |=> acc_out == $past(swp) && $stable(zero_out) && !fwr_out.we)
        else $error("swap to accumulator wrong");
    // side load may legally move acc, so it is excluded where acc must hold
    a_swap_file: assert property (
        sw && w[5] && !acc_load_in |=> fwr_out.we && fwr_out.addr == $past(fa)
        && fwr_out.data == $past(swp) && $stable(acc_out))
        else $error("swap to file wrong");
    a_dir_load: assert property (
        dl |=> dir_out == $past(acc_out) && $stable(zero_out))
        else $error("direction load wrong");
    a_xor_lit: assert property (
        xl |=> acc_out == $past(xr) && !fwr_out.we)
        else $error("literal xor wrong");
    a_xor_file: assert property (
        xf && w[5] && !acc_load_in |=> fwr_out.we && fwr_out.data == $past(xr)
        && $stable(acc_out))
        else $error("file xor to file wrong");
    a_xorf_acc: assert property (
        xf && !w[5] |=> acc_out == $past(xr) && !fwr_out.we)
        else $error("file xor to accumulator wrong");
    a_zero_flag: assert property (
        xl || xf |=> zero_out == ($past(xr) == 8'h00))
        else $error("zero flag wrong");
    a_done_pulse: assert property (
        sw || xf || xl || dl |=> done_out)
        else $error("done missing");
endmodule : nsx_exec_chk

bind nsx_exec nsx_exec_chk u_chk (.clock_in(clock_in), .srst_in(srst_in), .req_in(req_in),
    .acc_load_in(acc_load_in), .acc_out(acc_out), .dir_out(dir_out), .zero_out(zero_out),
    .fwr_out(fwr_out), .done_out(done_out));

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench
    import nsx_pkg::*;
;
    logic       clock_in = 1'b0;
    logic       srst_in  = 1'b1;
    nsx_req_t   req_in   = '0;
    logic       acc_load_in = 1'b0;
    logic [7:0] acc_load_data_in = 8'h00;
    logic [7:0] acc_out, dir_out;
    logic       zero_out, done_out, other_out, z;
    nsx_fwr_t   fwr_out;
    nsx_op_t    last_op_out;
    int         n_mismatch = 0, compares = 0, cycles = 0;

    nsx_exec dut (.clock_in(clock_in), .srst_in(srst_in), .req_in(req_in),
        .acc_load_in(acc_load_in), .acc_load_data_in(acc_load_data_in), .acc_out(acc_out),
        .dir_out(dir_out), .zero_out(zero_out), .fwr_out(fwr_out), .done_out(done_out),
        .other_out(other_out), .last_op_out(last_op_out));

    always #5 clock_in = ~clock_in;

    // a hang ends the run through the same verdict path
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            results();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // valid stays high between calls so ops run back to back
    task op(input logic [11:0] w, input logic [7:0] f);
        req_in = {1'b1, w, f};
        @(posedge clock_in);
        #1;
    endtask : op

    task ld(input logic [7:0] d);
        req_in.valid = 1'b0;
        acc_load_in = 1'b1;
        acc_load_data_in = d;
        @(posedge clock_in);
        #1;
        acc_load_in = 1'b0;
    endtask : ld

    task t_swap;
        ld(8'h33);
        op(12'h385, 8'ha5);
        chk(acc_out, 8'h5a);
        chk({7'h0, fwr_out.we}, 8'h00);
        chk({7'h0, done_out}, 8'h01);
        chk({5'h0, last_op_out}, {5'h0, NSX_OP_SWAP});
        op(12'h3bf, 8'h0f);
        chk({fwr_out.we, 2'h0, fwr_out.addr}, 8'h9f);
        chk(fwr_out.data, 8'hf0);
        chk(acc_out, 8'h5a);
    endtask : t_swap

    task t_xorl;
        ld(8'hb5);
        chk({7'h0, done_out}, 8'h00);
        op(12'hfaf, 8'h00);
        chk({acc_out[6:0], zero_out}, 8'h34);
        chk({5'h0, last_op_out}, {5'h0, NSX_OP_XORL});
        op(12'hf1a, 8'h00);
        chk({7'h0, zero_out}, 8'h01);
        op(12'hfff, 8'h00);
        chk({acc_out[6:0], zero_out}, 8'hfe);
        acc_load_in = 1'b1;
        acc_load_data_in = 8'h77;
        op(12'hf0f, 8'h00);
        acc_load_in = 1'b0;
        chk(acc_out, 8'hf0);
    endtask : t_xorl

    task t_xorf;
        ld(8'hb5);
        op(12'h1a3, 8'haf);
        chk({fwr_out.we, 2'h0, fwr_out.addr}, 8'h83);
        chk(fwr_out.data, 8'h1a);
        chk({5'h0, last_op_out}, {5'h0, NSX_OP_XORF});
        chk({acc_out[6:0], zero_out}, 8'h6a);
        op(12'h183, 8'hb5);
        chk({acc_out[6:0], zero_out}, 8'h01);
        chk({7'h0, fwr_out.we}, 8'h00);
        op(12'h380, 8'h12);
        chk({acc_out[6:0], zero_out}, 8'h43);
    endtask : t_xorf

    task t_dirl;
        ld(8'ha5);
        z = zero_out;
        op(12'h006, 8'h00);
        chk(dir_out, 8'ha5);
        chk({7'h0, zero_out}, {7'h0, z});
        chk({5'h0, last_op_out}, {5'h0, NSX_OP_DIRL});
        op(12'h003, 8'h00);
        chk({7'h0, other_out}, 8'h01);
        chk({7'h0, done_out}, 8'h00);
        chk(dir_out, 8'ha5);
        chk({5'h0, last_op_out}, {5'h0, NSX_OP_DIRL});
        ld(8'h3c);
        op(12'h006, 8'h00);
        chk(dir_out, 8'h3c);
    endtask : t_dirl

    // mid-run reset: state returns to its reset values, first word after release runs
    task t_rst;
        req_in.valid = 1'b0;
        srst_in = 1'b1;
        @(posedge clock_in);
        #1;
        srst_in = 1'b0;
        chk(acc_out, 8'h00);
        chk(dir_out, 8'hff);
        chk({5'h0, fwr_out.we, zero_out, done_out}, 8'h00);
        chk({5'h0, last_op_out}, {5'h0, NSX_OP_NONE});
        op(12'hf00, 8'h00);
        chk({acc_out[6:0], zero_out}, 8'h01);
    endtask : t_rst

    task results;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    initial begin
        repeat (3) @(posedge clock_in);
        #1;
        srst_in = 1'b0;
        chk(dir_out, 8'hff);
        t_swap();
        t_xorl();
        t_xorf();
        t_dirl();
        t_rst();
        results();
    end
endmodule : testbench
